// *** shared/atc_pkg.sv ***
// ==========================================================================
// Shared constants for the timer bank and comparator
package atc_pkg;

  // ==========================================================================
  // Clock and time base
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_TIME_MS  = 1;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned S_PER_MIN     = 60;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_TIMERS    = 32;
  localparam int unsigned DLY_W         = 16;
  localparam int unsigned ADDR_W        = 12;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] CMP_CTRL_OFS  = 12'h000;
  localparam logic [11:0] CMP_PKP_OFS   = 12'h004;
  localparam logic [11:0] CMP_HYST_OFS  = 12'h008;
  localparam logic [11:0] CMP_DLY_OFS   = 12'h00c;
  localparam logic [11:0] TMR_TYPE0_OFS = 12'h010;
  localparam logic [11:0] TMR_TYPE1_OFS = 12'h014;
  localparam logic [11:0] STATUS_OFS    = 12'h018;
  localparam logic [11:0] TMR_STATE_OFS = 12'h01c;
  localparam logic [11:0] RATE_CFG_OFS  = 12'h020;
  localparam logic [11:0] OPSIG_OFS     = 12'h024;
  localparam logic [11:0] TMR_DLY_OFS   = 12'h100;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_POS_ON   = 0;
  localparam int unsigned CTRL_NEG_ON   = 1;
  localparam int unsigned CTRL_ABS      = 2;
  localparam int unsigned CTRL_DELTA    = 3;
  localparam int unsigned CTRL_UNDER    = 4;
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned HYST_W        = 8;
  localparam int unsigned RATE_UNIT_LSB = 16;
  localparam int unsigned RATE_CFG_W    = 18;
  localparam int unsigned DLY_HI_LSB    = 16;

  // ==========================================================================
  // Reset values
  localparam logic [CTRL_W-1:0]     CTRL_RST     = 5'h00;
  localparam logic [31:0]           PKP_RST      = 32'h0000_0000;
  localparam logic [HYST_W-1:0]     HYST_RST     = 8'h00;
  localparam logic [31:0]           DLY_RST      = 32'h0000_0000;
  localparam logic [63:0]           TMR_TYPE_RST = 64'h0;
  localparam logic [RATE_CFG_W-1:0] RATE_CFG_RST = 18'h00000;

  // ==========================================================================
  // Time units of timers and of the rate interval
  typedef enum logic [1:0] {
    ATC_UNIT_MS,
    ATC_UNIT_S,
    ATC_UNIT_MIN,
    ATC_UNIT_MIN_ALT
  } atc_unit_e;

  // ==========================================================================
  // Quantity type codes and per-unit bases
  localparam logic [3:0]  QTY_FREQ       = 4'h1;
  localparam logic [3:0]  QTY_ANGLE      = 4'h2;
  localparam logic [3:0]  QTY_TEMP       = 4'h3;
  localparam int unsigned PU_SHIFT       = 24;
  localparam int unsigned FREQ_BASE_HZ   = 1;
  localparam int unsigned ANGLE_BASE_DEG = 360;
  localparam int unsigned TEMP_BASE_C    = 100;
  localparam int unsigned HYST_FULL_PCT  = 100;
  localparam int unsigned UNITY_RECIP    = 1 << PU_SHIFT;
  localparam int unsigned FREQ_RECIP     = UNITY_RECIP / FREQ_BASE_HZ;
  localparam int unsigned ANGLE_RECIP    = UNITY_RECIP / ANGLE_BASE_DEG;
  localparam int unsigned TEMP_RECIP     = UNITY_RECIP / TEMP_BASE_C;
  localparam int unsigned HYST_RECIP     = UNITY_RECIP / HYST_FULL_PCT;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

endpackage : atc_pkg

// *** rtl/atc_tick.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Millisecond, second and minute tick pulses
module atc_tick #(
  parameter int unsigned MS_CYCLES = atc_pkg::MS_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick_ms,
  output logic      tick_s,
  output logic      tick_min
);
  import atc_pkg::*;

  localparam int unsigned CW = $clog2(MS_CYCLES + 1);

  logic [CW-1:0] cyc_r;
  logic [9:0]    ms_r;
  logic [5:0]    s_r;

  wire ms_end  = (cyc_r == CW'(MS_CYCLES - 1));
  wire s_end   = ms_end && (ms_r == 10'(MS_PER_S - 1));
  wire min_end = s_end && (s_r == 6'(S_PER_MIN - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r    <= '0;
      ms_r     <= '0;
      s_r      <= '0;
      tick_ms  <= 1'b0;
      tick_s   <= 1'b0;
      tick_min <= 1'b0;
    end else begin
      cyc_r    <= ms_end ? '0 : cyc_r + CW'(1);
      if (ms_end) begin
        ms_r <= s_end ? 10'h000 : ms_r + 10'h001;
      end
      if (s_end) begin
        s_r <= min_end ? 6'h00 : s_r + 6'h01;
      end
      tick_ms  <= ms_end;
      tick_s   <= s_end;
      tick_min <= min_end;
    end
  end

endmodule : atc_tick

// *** rtl/atc_top.sv ***
`timescale 1ns/1ps
// What this block does
// - Thirty-two identical logic timers are offered as operators to the logic engine.
// - Each timer has a pickup delay and a dropout delay, and zero means no delay.
// - Each timer has a type field choosing the time unit of its two delays.
// - The comparator works on the plus input minus the inverted input, an off input being zero.
// - With no comparator input selected the comparator outputs never assert.
// - The comparator does not operate when its two selected inputs differ in quantity type.
// - Signed mode uses the difference as is, absolute mode uses its magnitude.
// - Threshold mode evaluates the signal itself, delta mode its rate of change.
// - Over picks up above the pickup value, under picks up below it.
// - Signal and pickup value are both signed and may be negative.
// - Dropout follows a hysteresis band set as a percentage of the pickup value.
// - In delta mode the rate is taken over an interval length in its own time unit.
// - The comparator output waits an assert delay to set and a reset delay to clear.
// - The pickup is per unit, with bases 1 Hz, 360 degrees and 100 degrees Celsius.
module atc_top #(
  parameter int unsigned MS_CYCLES = atc_pkg::MS_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [atc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [atc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [atc_pkg::NUM_TIMERS-1:0] timer_in,
  output logic [atc_pkg::NUM_TIMERS-1:0]   timer_out,
  input  wire logic signed [31:0]          pos_value,
  input  wire logic [3:0]                  pos_type,
  input  wire logic signed [31:0]          neg_value,
  input  wire logic [3:0]                  neg_type,
  output logic                             cmp_pickup,
  output logic                             cmp_out
);
  import atc_pkg::*;

  // ==========================================================================
  // Functions
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  function automatic logic signed [33:0] to_pu(input logic signed [31:0] v,
                                               input logic [3:0]         q);
    logic signed [25:0] recip;
    logic signed [57:0] prod;
    case (q)
      QTY_FREQ:  recip = 26'(FREQ_RECIP);
      QTY_ANGLE: recip = 26'(ANGLE_RECIP);
      QTY_TEMP:  recip = 26'(TEMP_RECIP);
      default:   recip = 26'(UNITY_RECIP);
    endcase
    prod = v * recip;
    return prod[57:24];
  endfunction : to_pu

  function automatic logic unit_tick(input logic [1:0] u, input logic [2:0] t);
    logic r;
    case (atc_unit_e'(u))
      ATC_UNIT_MS: r = t[0];
      ATC_UNIT_S:  r = t[1];
      default:     r = t[2];
    endcase
    return r;
  endfunction : unit_tick

  // Returns next output and next count of a pickup and dropout delay stage
  function automatic logic [DLY_W:0] delay_step(input logic             din,
                                                input logic             dout,
                                                input logic [DLY_W-1:0] cnt,
                                                input logic [DLY_W-1:0] pkp,
                                                input logic [DLY_W-1:0] drp,
                                                input logic             tick);
    logic [DLY_W-1:0] dly;
    logic [DLY_W:0]   r;
    dly = din ? pkp : drp;
    if (din == dout) begin
      r = {dout, {DLY_W{1'b0}}};
    end else if (dly == '0) begin
      r = {din, {DLY_W{1'b0}}};
    end else if (tick && ({1'b0, cnt} + 17'h00001 >= {1'b0, dly})) begin
      r = {din, {DLY_W{1'b0}}};
    end else if (tick) begin
      r = {dout, cnt + 16'h0001};
    end else begin
      r = {dout, cnt};
    end
    return r;
  endfunction : delay_step

  // ==========================================================================
  // Time base
  logic tick_ms;
  logic tick_s;
  logic tick_min;

  atc_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_ms  (tick_ms),
    .tick_s   (tick_s),
    .tick_min (tick_min)
  );

  wire [2:0] ticks = {tick_min, tick_s, tick_ms};

  // ==========================================================================
  // Registers
  logic [CTRL_W-1:0]     ctrl_r;
  logic signed [31:0]    pkp_r;
  logic [HYST_W-1:0]     hyst_r;
  logic [31:0]           cmp_dly_r;
  logic [63:0]           tmr_type_r;
  logic [RATE_CFG_W-1:0] rate_cfg_r;
  logic [31:0]           tmr_dly_r [NUM_TIMERS];
  logic [DLY_W-1:0]      tmr_cnt_r [NUM_TIMERS];
  logic [DLY_W-1:0]      cmp_cnt_r;
  logic                  pick_r;
  logic signed [35:0]    prev_r;
  logic signed [35:0]    rate_r;
  logic [DLY_W-1:0]      rate_cnt_r;

  // ==========================================================================
  // AXI4-Lite write channel
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  wire aw_fire   = s_axi_awvalid & s_axi_awready;
  wire w_fire    = s_axi_wvalid & s_axi_wready;
  wire wr_do     = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire aw_nxt    = wr_do ? 1'b0 : (aw_got_r | aw_fire);
  wire w_nxt     = wr_do ? 1'b0 : (w_got_r | w_fire);
  wire [9:0] wa  = awaddr_r[11:2];
  wire wr_ctrl   = wr_do && (wa == CMP_CTRL_OFS[11:2]);
  wire wr_pkp    = wr_do && (wa == CMP_PKP_OFS[11:2]);
  wire wr_hyst   = wr_do && (wa == CMP_HYST_OFS[11:2]);
  wire wr_cdly   = wr_do && (wa == CMP_DLY_OFS[11:2]);
  wire wr_type0  = wr_do && (wa == TMR_TYPE0_OFS[11:2]);
  wire wr_type1  = wr_do && (wa == TMR_TYPE1_OFS[11:2]);
  wire wr_rate   = wr_do && (wa == RATE_CFG_OFS[11:2]);
  wire wr_ro     = (wa == STATUS_OFS[11:2]) || (wa == TMR_STATE_OFS[11:2]) ||
                   (wa == OPSIG_OFS[11:2]);
  wire wr_tmr    = wr_do && (awaddr_r[11:7] == TMR_DLY_OFS[11:7]);
  wire wr_known  = wr_ctrl | wr_pkp | wr_hyst | wr_cdly | wr_type0 | wr_type1 |
                   wr_rate | wr_tmr | (wr_do & wr_ro);
  wire [4:0] wtmr = awaddr_r[6:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_got_r      <= aw_nxt;
      w_got_r       <= w_nxt;
      s_axi_awready <= ~aw_nxt;
      s_axi_wready  <= ~w_nxt;
      if (aw_fire) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration storage
  logic [31:0] ctrl_w;
  logic [31:0] hyst_w;
  logic [31:0] rate_w;
  assign ctrl_w = apply_strb({27'h0, ctrl_r}, wdata_r, wstrb_r);
  assign hyst_w = apply_strb({24'h0, hyst_r}, wdata_r, wstrb_r);
  assign rate_w = apply_strb({14'h0, rate_cfg_r}, wdata_r, wstrb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= CTRL_RST;
      pkp_r      <= PKP_RST;
      hyst_r     <= HYST_RST;
      cmp_dly_r  <= DLY_RST;
      tmr_type_r <= TMR_TYPE_RST;
      rate_cfg_r <= RATE_CFG_RST;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        tmr_dly_r[i] <= DLY_RST;
      end
    end else begin
      if (wr_ctrl)  ctrl_r     <= ctrl_w[CTRL_W-1:0];
      if (wr_pkp)   pkp_r      <= apply_strb(pkp_r, wdata_r, wstrb_r);
      if (wr_hyst)  hyst_r     <= hyst_w[HYST_W-1:0];
      if (wr_cdly)  cmp_dly_r  <= apply_strb(cmp_dly_r, wdata_r, wstrb_r);
      if (wr_type0) tmr_type_r[31:0]  <= apply_strb(tmr_type_r[31:0], wdata_r, wstrb_r);
      if (wr_type1) tmr_type_r[63:32] <= apply_strb(tmr_type_r[63:32], wdata_r, wstrb_r);
      if (wr_rate)  rate_cfg_r <= rate_w[RATE_CFG_W-1:0];
      if (wr_tmr)   tmr_dly_r[wtmr] <= apply_strb(tmr_dly_r[wtmr], wdata_r, wstrb_r);
    end
  end

  // ==========================================================================
  // Timer bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        tmr_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        {timer_out[i], tmr_cnt_r[i]} <= delay_step(timer_in[i], timer_out[i],
                                          tmr_cnt_r[i],
                                          tmr_dly_r[i][DLY_W-1:0],
                                          tmr_dly_r[i][DLY_HI_LSB +: DLY_W],
                                          unit_tick(tmr_type_r[2*i +: 2], ticks));
      end
    end
  end

  // ==========================================================================
  // Comparator operating signal
  wire pos_on    = ctrl_r[CTRL_POS_ON];
  wire neg_on    = ctrl_r[CTRL_NEG_ON];
  wire mismatch  = pos_on && neg_on && (pos_type != neg_type);
  wire cmp_en    = (pos_on | neg_on) & ~mismatch;

  wire signed [33:0] pos_pu = pos_on ? to_pu(pos_value, pos_type) : 34'sh0;
  wire signed [33:0] neg_pu = neg_on ? to_pu(neg_value, neg_type) : 34'sh0;
  wire signed [35:0] diff   = 36'(pos_pu) - 36'(neg_pu);
  wire signed [35:0] op_sig = (ctrl_r[CTRL_ABS] && diff[35]) ? -diff : diff;

  // ==========================================================================
  // Rate of change over the interval
  wire [DLY_W-1:0] rate_len  = rate_cfg_r[DLY_W-1:0];
  wire             rate_tick = unit_tick(rate_cfg_r[RATE_UNIT_LSB +: 2], ticks);
  wire             rate_end  = rate_tick &&
                               ({1'b0, rate_cnt_r} + 17'h00001 >= {1'b0, rate_len});

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r[CTRL_DELTA]) begin
      rate_cnt_r <= '0;
      prev_r     <= '0;
      rate_r     <= '0;
    end else if (rate_end) begin
      rate_cnt_r <= '0;
      prev_r     <= op_sig;
      rate_r     <= op_sig - prev_r;
    end else if (rate_tick) begin
      rate_cnt_r <= rate_cnt_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Threshold with hysteresis
  wire signed [35:0] eval_sig = ctrl_r[CTRL_DELTA] ? rate_r : op_sig;
  wire signed [35:0] pkp_ext  = 36'(pkp_r);
  wire [31:0]        pkp_mag  = pkp_r[31] ? 32'(-pkp_r) : 32'(pkp_r);
  wire [57:0]        band_raw = 58'(pkp_mag) * 58'(hyst_r) * 58'(HYST_RECIP);
  wire signed [35:0] band     = 36'(band_raw[57:PU_SHIFT]);
  wire signed [35:0] drop_lo  = pkp_ext - band;
  wire signed [35:0] drop_hi  = pkp_ext + band;
  wire under    = ctrl_r[CTRL_UNDER];
  wire set_cond = under ? (eval_sig < pkp_ext) : (eval_sig > pkp_ext);
  wire drop_cond = under ? (eval_sig > drop_hi) : (eval_sig < drop_lo);
  wire pick_nxt = cmp_en && (pick_r ? !drop_cond : set_cond);

  // ==========================================================================
  // Output delays
  logic [DLY_W:0] cmp_step;
  assign cmp_step = delay_step(pick_r, cmp_out, cmp_cnt_r,
                               cmp_dly_r[DLY_W-1:0],
                               cmp_dly_r[DLY_HI_LSB +: DLY_W], tick_ms);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pick_r     <= 1'b0;
      cmp_pickup <= 1'b0;
      cmp_out    <= 1'b0;
      cmp_cnt_r  <= '0;
    end else begin
      pick_r     <= pick_nxt;
      cmp_pickup <= pick_nxt;
      cmp_out    <= cmp_en & cmp_step[DLY_W];
      cmp_cnt_r  <= cmp_en ? cmp_step[DLY_W-1:0] : '0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  wire [9:0] ra     = s_axi_araddr[11:2];
  wire       rd_tmr = (s_axi_araddr[11:7] == TMR_DLY_OFS[11:7]);
  wire       ar_fire = s_axi_arvalid & s_axi_arready;
  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    if (rd_tmr) begin
      rd_mux = tmr_dly_r[s_axi_araddr[6:2]];
    end else if (ra == CMP_CTRL_OFS[11:2]) begin
      rd_mux = {27'h0, ctrl_r};
    end else if (ra == CMP_PKP_OFS[11:2]) begin
      rd_mux = pkp_r;
    end else if (ra == CMP_HYST_OFS[11:2]) begin
      rd_mux = {24'h0, hyst_r};
    end else if (ra == CMP_DLY_OFS[11:2]) begin
      rd_mux = cmp_dly_r;
    end else if (ra == TMR_TYPE0_OFS[11:2]) begin
      rd_mux = tmr_type_r[31:0];
    end else if (ra == TMR_TYPE1_OFS[11:2]) begin
      rd_mux = tmr_type_r[63:32];
    end else if (ra == STATUS_OFS[11:2]) begin
      rd_mux = {28'h0, mismatch, cmp_en, cmp_pickup, cmp_out};
    end else if (ra == TMR_STATE_OFS[11:2]) begin
      rd_mux = timer_out;
    end else if (ra == RATE_CFG_OFS[11:2]) begin
      rd_mux = {14'h0, rate_cfg_r};
    end else if (ra == OPSIG_OFS[11:2]) begin
      rd_mux = eval_sig[31:0];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

endmodule : atc_top

// *** test/atc_top_asserts.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Port checks
module atc_top_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] timer_in,
  input wire logic [31:0] timer_out,
  input wire logic        cmp_pickup,
  input wire logic        cmp_out
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_timer_cause: assert property ((((timer_out ^ $past(timer_out)) &
    ~($past(timer_in) ^ $past(timer_out)))) == 32'h0) else $error("timer moved alone");
  chk_rise_cause: assert property ($rose(cmp_out) |-> $past(cmp_pickup))
    else $error("output rose without pickup");
  chk_fall_cause: assert property ($fell(cmp_out) |-> !$past(cmp_pickup) || !cmp_pickup)
    else $error("output fell with pickup");
  chk_b_late: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_r_late: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule : atc_top_asserts

bind atc_top atc_top_asserts u_atc_top_asserts (.*);

// *** test/atc_partner.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Measurement source and logic engine model
module atc_partner (
  input  wire logic        [31:0] set_pv,
  input  wire logic        [3:0]  set_pt,
  input  wire logic        [31:0] set_nv,
  input  wire logic        [3:0]  set_nt,
  input  wire logic        [31:0] set_tin,
  output logic signed      [31:0] pos_value,
  output logic             [3:0]  pos_type,
  output logic signed      [31:0] neg_value,
  output logic             [3:0]  neg_type,
  output logic             [31:0] timer_in
);
  assign pos_value = set_pv;
  assign pos_type  = set_pt;
  assign neg_value = set_nv;
  assign neg_type  = set_nt;
  assign timer_in  = set_tin;
endmodule : atc_partner

// *** test/test_atc_top.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Bus tasks and sequences
module test_atc_top;
  import atc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, set_pv = 32'h0, set_nv = 32'h0, set_tin = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, set_pt = 4'h0, set_nt = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cmp_pickup, cmp_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, timer_in, timer_out;
  logic signed [31:0] pos_value, neg_value;
  logic [3:0] pos_type, neg_type;
  int miscompares = 0, total_checks = 0, cyc = 0;
  atc_top #(.MS_CYCLES(10)) u_atc_top (.*);
  atc_partner u_atc_partner (.*);
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask : cy
  task automatic wp(input logic e, input int n);
    cy(3);
    repeat (n) if (cmp_pickup !== e) @(posedge aclk);
    chk({31'h0, cmp_pickup}, {31'h0, e});
  endtask : wp
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd
  initial begin
    cy(20);
    aresetn <= 1'b1;
    rd(CMP_CTRL_OFS, 32'h0, RESP_OKAY);
    rd(12'hffc, 32'h0, RESP_SLVERR);
    wr(12'hffc, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'hffff_ffff);
    rd(STATUS_OFS, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(CMP_PKP_OFS, 32'hffff_ff5a);
    s_axi_wstrb <= 4'hf;
    rd(CMP_PKP_OFS, 32'h0000_005a, RESP_OKAY);
    wr(TMR_DLY_OFS, 32'h0000_0003);
    wr(TMR_DLY_OFS + 12'h014, 32'h0002_0000);
    wr(TMR_DLY_OFS + 12'h07c, 32'h0000_0002);
    wr(TMR_TYPE1_OFS, 32'h4000_0000);
    rd(TMR_DLY_OFS + 12'h07c, 32'h0000_0002, RESP_OKAY);
    set_tin <= 32'h8000_0021;
    cy(15);
    set_tin[0] <= 1'b0;
    cy(1);
    set_tin[0] <= 1'b1;
    cy(15);
    chk(timer_out, 32'h0000_0020);
    cy(20);
    chk(timer_out, 32'h0000_0021);
    set_tin <= 32'h8000_0000;
    cy(5);
    chk(timer_out, 32'h0000_0020);
    cy(30);
    chk(timer_out, 32'h0);
    cy(9000);
    chk(timer_out, 32'h0);
    cy(12000);
    chk(timer_out, 32'h8000_0000);
    wr(CMP_HYST_OFS, 32'h0000_0032);
    wr(CMP_PKP_OFS, 32'h0001_0000);
    wr(CMP_CTRL_OFS, 32'h1);
    set_pv <= 32'h0002_0000;
    wp(1'b1, 10);
    chk({31'h0, cmp_out}, 32'h1);
    set_pv <= 32'h0000_c000;
    wp(1'b1, 10);
    set_pv <= 32'h0000_6000;
    wp(1'b0, 10);
    wr(CMP_PKP_OFS, 32'hffff_0000);
    wr(CMP_CTRL_OFS, 32'h11);
    set_pv <= 32'hfffe_0000;
    wp(1'b1, 10);
    set_pv <= 32'hffff_4000;
    wp(1'b1, 10);
    set_pv <= 32'h0;
    wp(1'b0, 10);
    wr(CMP_HYST_OFS, 32'h0);
    wr(CMP_PKP_OFS, 32'h0001_0000);
    wr(CMP_CTRL_OFS, 32'h3);
    set_nv <= 32'h0002_0000;
    wp(1'b0, 10);
    wr(CMP_CTRL_OFS, 32'h7);
    wp(1'b1, 10);
    set_nt <= 4'h2;
    wp(1'b0, 10);
    set_nt <= 4'h0;
    wp(1'b1, 10);
    wr(CMP_CTRL_OFS, 32'h4);
    wp(1'b0, 10);
    wr(CMP_CTRL_OFS, 32'h1);
    for (int i = 2; i < 4; i++) begin
      set_pt <= 4'(i);
      set_pv <= (i == 2) ? 32'h00b4_0000 : 32'h0032_0000;
      wr(CMP_PKP_OFS, 32'h0000_999a);
      wp(1'b0, 10);
      wr(CMP_PKP_OFS, 32'h0000_6666);
      wp(1'b1, 10);
    end
    wr(CMP_DLY_OFS, 32'h0002_0003);
    wr(CMP_PKP_OFS, 32'h0000_999a);
    cy(5);
    chk({31'h0, cmp_out}, 32'h1);
    cy(30);
    chk({31'h0, cmp_out}, 32'h0);
    wr(CMP_PKP_OFS, 32'h0000_6666);
    cy(12);
    chk({31'h0, cmp_out}, 32'h0);
    cy(30);
    chk({31'h0, cmp_out}, 32'h1);
    wr(CMP_DLY_OFS, 32'h0);
    wr(CMP_PKP_OFS, 32'h0000_8000);
    wr(RATE_CFG_OFS, 32'h2);
    set_pt <= 4'h0;
    set_pv <= 32'h0;
    wr(CMP_CTRL_OFS, 32'h9);
    wp(1'b0, 50);
    set_pv <= 32'h0001_0000;
    wp(1'b1, 30);
    wp(1'b0, 30);
    end_sim();
  end
endmodule : test_atc_top
